// ### include/fspid_pkg.sv
// Package of constants and types for the flash status-protect and ident block
package fspid_pkg;

   // ==========================================================
   // Opcodes seen on the serial link
   localparam logic [7:0] OP_STATUS_WRITE_ARM = 8'h50;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STANDARD_IDENT = 8'h9F;
   localparam logic [7:0] OP_LEGACY_IDENT_A = 8'h90;
   localparam logic [7:0] OP_LEGACY_IDENT_B = 8'hAB;

   // ==========================================================
   // Identification values (arbitrary neutral values)
   localparam logic [7:0] ID_MANUFACTURER = 8'h5A;
   localparam logic [7:0] ID_MEMORY_TYPE = 8'h3C;
   localparam logic [7:0] ID_CAPACITY = 8'h11;

   // ==========================================================
   // Status register field positions and reset value
   localparam int ST_WEL_POS = 1;
   localparam int ST_BP_LSB = 2;
   localparam int ST_BP_MSB = 5;
   localparam int ST_LOCK_POS = 7;
   localparam logic [7:0] ST_RESET = 8'h1C;
   localparam logic [7:0] ST_WRITE_MASK = 8'hBC;

   // ==========================================================
   // Frame counts
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_ADDR_END = 6'h20;

   // Decoded link events from the edge finder
   typedef struct packed {
      logic sel;
      logic sck_rise;
      logic sck_fall;
      logic frame_end;
      logic mosi;
   } fspid_link_type;

   // Frame decode states
   typedef enum logic [4:0] {
      ST_OPCODE = 5'b00001,
      ST_WDATA = 5'b00010,
      ST_ADDR = 5'b00100,
      ST_OUT = 5'b01000,
      ST_IGNORE = 5'b10000
   } fspid_state_type;

endpackage : fspid_pkg

// ### core/fspid_sync.sv
// Pin synchroniser and edge finder for the serial link
`timescale 1ns/1ps
module fspid_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Raw pins
   input wire logic cs_b_pin,
   input wire logic sck_pin,
   input wire logic mosi_pin,
   // Decoded events
   output fspid_pkg::fspid_link_type link
);

   // ==========================================================
   // Two-stage synchronisers; stage one is read only by stage two
   logic [2:0] s1_r, s1_nxt;
   logic [2:0] s2_r, s2_nxt;
   logic [1:0] prev_r, prev_nxt; // Last cs_b, sck for edges

   // Next-state logic
   always_comb begin
      s1_nxt = {cs_b_pin, sck_pin, mosi_pin};
      s2_nxt = s1_r;
      prev_nxt = s2_r[2:1];
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s1_r <= 3'h7;
         s2_r <= 3'h7;
         prev_r <= 2'h3;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         prev_r <= prev_nxt;
      end
   end

   // Events: a rising edge of chip select ends the frame
   always_comb begin
      link.sel = ~s2_r[2];
      link.sck_rise = ~s2_r[2] & s2_r[1] & ~prev_r[0];
      link.sck_fall = ~s2_r[2] & ~s2_r[1] & prev_r[0];
      link.frame_end = s2_r[2] & ~prev_r[1];
      link.mosi = s2_r[0];
   end

endmodule : fspid_sync

// ### core/fspid_shift.sv
// Output shifter: loads a byte and sends it MSB first on falling edges
`timescale 1ns/1ps
module fspid_shift (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic load,
   input wire logic [7:0] load_byte,
   input wire logic shift,
   input wire logic stop,
   // Serial output
   output logic miso,
   output logic miso_oe
);

   logic [7:0] sh_r, sh_nxt; // Byte in flight
   logic oe_r, oe_nxt; // Drive enable

   // ==========================================================
   // Next values; stop beats everything so the pin is freed at once
   always_comb begin
      sh_nxt = sh_r;
      oe_nxt = oe_r;
      if (stop) begin
         oe_nxt = 1'b0;
      end else if (load) begin
         sh_nxt = load_byte;
         oe_nxt = 1'b1;
      end else if (shift) begin
         sh_nxt = {sh_r[6:0], 1'b0};
      end
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sh_r <= 8'h00;
         oe_r <= 1'b0;
      end else begin
         sh_r <= sh_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign miso = sh_r[7];
   assign miso_oe = oe_r;

endmodule : fspid_shift

// ### core/fspid_top.sv
// Status-protect and identification decoder of a serial flash
`timescale 1ns/1ps
// Overview of operation
// - Status write works only right after arming or while write enable is set
// - Write changes only block-protect and lock bits
// - Locked with protect pin low: ignore write
// - Pin low: lock may only be set
// - Pin high: all protect bits freely writable
// - Lock and protect bits settable in one write
// - Standard ident opcode shifts identification out
// - Manufacturer byte, then type, then capacity
// - Chip select high stops ident output
// - Legacy ident: two opcodes, 24-bit address
// - Address zero manufacturer, address one device
// - Legacy output alternates until chip select high
// - Write enable also arms; cleared at write end
module fspid_top (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Serial link pins
   input wire logic CS_B,
   input wire logic SCK,
   input wire logic MOSI,
   input wire logic WP_B,
   output logic MISO,
   output logic MISO_OE,
   // Status view
   output logic [7:0] STATUS,
   output logic WRITE_ENABLE_LATCH,
   output logic ARMED
);

   // ==========================================================
   // Link front end
   fspid_pkg::fspid_link_type link;

   fspid_sync u_sync (
      .clk(CLK),
      .rst_b(RST_B),
      .cs_b_pin(CS_B),
      .sck_pin(SCK),
      .mosi_pin(MOSI),
      .link(link)
   );

   // ==========================================================
   // Write-protect pin synchroniser; the pin is a slow level, so two
   // flip-flops are enough and only the second is ever decoded
   logic wp1_r, wp1_nxt; // First stage, read only by the second
   logic wp2_r, wp2_nxt; // Settled level of the pin

   // Next values of the two stages
   always_comb begin
      wp1_nxt = WP_B;
      wp2_nxt = wp1_r;
   end

   // Registers; reset to the unprotected level so no lock-down is
   // seen before the pin has been sampled twice
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         wp1_r <= 1'b1;
         wp2_r <= 1'b1;
      end else begin
         wp1_r <= wp1_nxt;
         wp2_r <= wp2_nxt;
      end
   end

   // ==========================================================
   // Frame state
   fspid_pkg::fspid_state_type state_r, state_nxt;
   logic [5:0] cnt_r, cnt_nxt; // Bits taken this frame
   logic [7:0] in_r, in_nxt; // Input shifter
   logic [7:0] op_r, op_nxt; // Opcode of frame
   logic [7:0] wdata_r, wdata_nxt; // Data byte for status write
   logic wdata_ok_r, wdata_ok_nxt; // Full data byte seen
   logic addr0_r, addr0_nxt; // Address LSB, stored but never read; byte_r picks the legacy byte
   logic [1:0] byte_r, byte_nxt; // Output byte index
   logic [2:0] obit_r, obit_nxt; // Output bit index
   logic started_r, started_nxt; // First falling edge passed
   logic [7:0] status_r, status_nxt;
   logic arm_r, arm_nxt; // Arming from the arming opcode

   // Output shifter controls
   logic load;
   logic [7:0] load_byte;
   logic shift;
   logic [7:0] in_next_byte;

   // Byte to send for a given ident mode and index
   function automatic logic [7:0] ident_byte(input logic legacy,
                                             input logic [1:0] idx);
      logic [7:0] b;
      b = fspid_pkg::ID_MANUFACTURER;
      if (legacy) begin
         if (idx[0]) begin
            b = fspid_pkg::ID_CAPACITY;
         end
      end else begin
         unique case (idx)
            2'h1: b = fspid_pkg::ID_MEMORY_TYPE;
            2'h2: b = fspid_pkg::ID_CAPACITY;
            default: b = fspid_pkg::ID_MANUFACTURER;
         endcase
      end
      return b;
   endfunction : ident_byte

   // Opcode of a legacy ident request
   function automatic logic is_legacy(input logic [7:0] op);
      return (op == fspid_pkg::OP_LEGACY_IDENT_A) ||
             (op == fspid_pkg::OP_LEGACY_IDENT_B);
   endfunction : is_legacy

   // ==========================================================
   // Frame decoder, status register and arming
   // Chip select rising is handled before any clock event, so a frame
   // cut in mid-byte still ends cleanly and never commits a part byte
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      in_nxt = in_r;
      op_nxt = op_r;
      wdata_nxt = wdata_r;
      wdata_ok_nxt = wdata_ok_r;
      addr0_nxt = addr0_r;
      byte_nxt = byte_r;
      obit_nxt = obit_r;
      started_nxt = started_r;
      status_nxt = status_r;
      arm_nxt = arm_r;
      load = 1'b0;
      load_byte = 8'h00;
      shift = 1'b0;
      in_next_byte = {in_r[6:0], link.mosi};
      if (link.frame_end) begin
         // Commit happens only here, at chip select rising. The state
         // has already moved on once the data byte is in, so the frame
         // is known by its opcode and a complete data byte
         if (op_r == fspid_pkg::OP_STATUS_WRITE &&
             wdata_ok_r) begin
            // Armed by the arming opcode or by the write-enable latch
            if ((arm_r || status_r[fspid_pkg::ST_WEL_POS]) &&
                !(!wp2_r && status_r[fspid_pkg::ST_LOCK_POS])) begin
               // With the pin low the lock is 0 here, so it may only be set
               status_nxt = (status_r & ~fspid_pkg::ST_WRITE_MASK) |
                            (wdata_r & fspid_pkg::ST_WRITE_MASK);
            end
            status_nxt[fspid_pkg::ST_WEL_POS] = 1'b0;
            arm_nxt = 1'b0;
         end else if (op_r == fspid_pkg::OP_STATUS_WRITE_ARM &&
                      cnt_r == fspid_pkg::BITS_OPCODE) begin
            // Only a bare eight-bit arming frame arms the next frame
            arm_nxt = 1'b1;
         end else if (cnt_r >= fspid_pkg::BITS_OPCODE) begin
            arm_nxt = 1'b0;
            if (op_r == fspid_pkg::OP_WRITE_ENABLE) begin
               status_nxt[fspid_pkg::ST_WEL_POS] = 1'b1;
            end else if (op_r == fspid_pkg::OP_WRITE_DISABLE) begin
               status_nxt[fspid_pkg::ST_WEL_POS] = 1'b0;
            end
         end
         state_nxt = fspid_pkg::ST_OPCODE;
         cnt_nxt = 6'h00;
         op_nxt = 8'h00;
         wdata_ok_nxt = 1'b0;
         byte_nxt = 2'h0;
         obit_nxt = 3'h0;
         started_nxt = 1'b0;
      end else if (link.sck_rise) begin
         // Sample MSB first on rising edges
         in_nxt = in_next_byte;
         // Saturate so a long readout never wraps into the opcode count
         if (cnt_r != 6'h3F) begin
            cnt_nxt = cnt_r + 6'h01;
         end
         unique case (state_r)
            fspid_pkg::ST_OPCODE: begin
               if (cnt_r == fspid_pkg::BITS_OPCODE - 6'h01) begin
                  op_nxt = in_next_byte;
                  if (in_next_byte == fspid_pkg::OP_STATUS_WRITE) begin
                     state_nxt = fspid_pkg::ST_WDATA;
                  end else if (in_next_byte ==
                               fspid_pkg::OP_STANDARD_IDENT) begin
                     state_nxt = fspid_pkg::ST_OUT;
                  end else if (is_legacy(in_next_byte)) begin
                     state_nxt = fspid_pkg::ST_ADDR;
                  end else begin
                     state_nxt = fspid_pkg::ST_IGNORE;
                  end
               end
            end
            fspid_pkg::ST_WDATA: begin
               if (cnt_r == fspid_pkg::BITS_OPCODE * 6'h02 - 6'h01) begin
                  wdata_nxt = in_next_byte;
                  wdata_ok_nxt = 1'b1;
                  state_nxt = fspid_pkg::ST_IGNORE;
                  op_nxt = fspid_pkg::OP_STATUS_WRITE;
               end
            end
            fspid_pkg::ST_ADDR: begin
               if (cnt_r == fspid_pkg::BITS_ADDR_END - 6'h01) begin
                  // Address LSB picks which legacy byte comes first
                  addr0_nxt = link.mosi;
                  byte_nxt = {1'b0, link.mosi};
                  state_nxt = fspid_pkg::ST_OUT;
               end
            end
            fspid_pkg::ST_OUT: begin
            end
            fspid_pkg::ST_IGNORE: begin
            end
         endcase
      end else if (link.sck_fall && state_r == fspid_pkg::ST_OUT) begin
         // Output changes on falling edges; the first fall after the
         // last opcode or address bit loads the first byte, so the host
         // sees its MSB on the very next rising edge
         if (!started_r || obit_r == 3'h7) begin
            load = 1'b1;
            load_byte = ident_byte(is_legacy(op_r), byte_r);
            started_nxt = 1'b1;
            obit_nxt = 3'h0;
            if (is_legacy(op_r)) begin
               byte_nxt = {1'b0, ~byte_r[0]};
            end else if (byte_r != 2'h2) begin
               byte_nxt = byte_r + 2'h1;
            end else begin
               byte_nxt = 2'h0;
            end
         end else begin
            shift = 1'b1;
            obit_nxt = obit_r + 3'h1;
         end
      end
      // A frame that ends in the wdata state returns to the opcode state
      if (state_r == fspid_pkg::ST_WDATA && link.frame_end) begin
         state_nxt = fspid_pkg::ST_OPCODE;
      end
   end

   // Registers
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         state_r <= fspid_pkg::ST_OPCODE;
         cnt_r <= 6'h00;
         in_r <= 8'h00;
         op_r <= 8'h00;
         wdata_r <= 8'h00;
         wdata_ok_r <= 1'b0;
         addr0_r <= 1'b0;
         byte_r <= 2'h0;
         obit_r <= 3'h0;
         started_r <= 1'b0;
         status_r <= fspid_pkg::ST_RESET;
         arm_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         in_r <= in_nxt;
         op_r <= op_nxt;
         wdata_r <= wdata_nxt;
         wdata_ok_r <= wdata_ok_nxt;
         addr0_r <= addr0_nxt;
         byte_r <= byte_nxt;
         obit_r <= obit_nxt;
         started_r <= started_nxt;
         status_r <= status_nxt;
         arm_r <= arm_nxt;
      end
   end

   // ==========================================================
   // Output shifter; released as soon as the frame ends. The data pin
   // keeps its last bit while the enable is low: the pad, not this
   // logic, decides what the far side then sees. Both pins leave the
   // shifter's own flip-flops, so no decode glitch reaches the link.
   logic miso_w; // Shifter MSB
   logic miso_oe_w; // Shifter drive enable

   fspid_shift u_shift (
      .clk(CLK),
      .rst_b(RST_B),
      .load(load),
      .load_byte(load_byte),
      .shift(shift),
      .stop(link.frame_end),
      .miso(miso_w),
      .miso_oe(miso_oe_w)
   );

   assign MISO = miso_w;
   assign MISO_OE = miso_oe_w;
   assign STATUS = status_r;
   assign WRITE_ENABLE_LATCH = status_r[fspid_pkg::ST_WEL_POS];
   assign ARMED = arm_r;

endmodule : fspid_top

// ### dv/fspid_assertions.sv
// Port checker for the status-protect and ident block
`timescale 1ns/1ps
module fspid_chk (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Link pins
   input wire logic CS_B,
   input wire logic SCK,
   input wire logic MOSI,
   input wire logic WP_B,
   input wire logic MISO,
   input wire logic MISO_OE,
   // Status view
   input wire logic [7:0] STATUS,
   input wire logic WRITE_ENABLE_LATCH,
   input wire logic ARMED
);
   // ==========================================================
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // ==========================================================
   // Assertions
   a_spare_bits_zero: assert property (!STATUS[6] && !STATUS[0])
      else $error("spare status bit set");
   a_status_cause: assert property (!$stable(STATUS[7:2]) |->
      $past(ARMED) || $past(WRITE_ENABLE_LATCH))
      else $error("status changed without arming");
   a_arm_at_end: assert property ($rose(ARMED) |-> CS_B)
      else $error("armed while selected");
   a_frame_status: assert property ((!CS_B)[*8] |=> $stable(STATUS))
      else $error("status changed inside a frame");
   a_lock_holds: assert property ((STATUS[7] && !WP_B)[*6] |=>
      $stable(STATUS[7:2]))
      else $error("locked status altered");
   a_wel_set: assert property ($rose(WRITE_ENABLE_LATCH) |->
      CS_B && STATUS[1])
      else $error("write enable latch set badly");
   a_oe_selected: assert property ($rose(MISO_OE) |-> !CS_B)
      else $error("output driven while deselected");
   a_oe_released: assert property (CS_B[*6] |-> !MISO_OE)
      else $error("output still driven after deselect");
   a_miso_hold: assert property ($fell(SCK) |=> $stable(MISO)[*2])
      else $error("output moved too soon after clock fall");
   // Main scenarios reached
   c_armed: cover property ($rose(ARMED));
   c_ident_out: cover property ($rose(MISO_OE));
   c_locked: cover property (STATUS[7] && !WP_B);
   c_wel_clear: cover property ($fell(WRITE_ENABLE_LATCH));
endmodule : fspid_chk

bind fspid_top fspid_chk u_fspid_chk (.CLK(CLK), .RST_B(RST_B),
   .CS_B(CS_B), .SCK(SCK), .MOSI(MOSI), .WP_B(WP_B), .MISO(MISO),
   .MISO_OE(MISO_OE), .STATUS(STATUS),
   .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .ARMED(ARMED));

// ### dv/fspid_host.sv
// Host serial controller model, mode 0, paced by the system clock
`timescale 1ns/1ps
module fspid_host (
   // Pacing clock
   input wire logic clk,
   // Link pins
   output logic cs_b,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   // ==========================================================
   // Idle: deselected, link clock parked low between frames
   initial begin
      cs_b = 1'b1;
      sck = 1'b0;
      mosi = 1'b0;
   end
   // Half of a 200 ns link period, just after a clock edge
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask : half
   // One framed transfer of n bits; reply taken late in the high
   // phase, where the device output has long settled
   task automatic frame(input int n, input logic [63:0] tx,
                        output logic [63:0] rx);
      rx = '0;
      half();
      cs_b = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = tx[i];
         half();
         sck = 1'b1;
         half();
         rx = {rx[62:0], miso};
         sck = 1'b0;
      end
      half();
      cs_b = 1'b1;
      // Released data line shows the inverse, never a stale value
      mosi = ~mosi;
      half();
      half();
   endtask : frame
endmodule : fspid_host

// ### dv/fspid_top_tb_top.sv
// Self-checking bench for the status-protect and ident block
`timescale 1ns/1ps
module fspid_top_tb_top;
   // ==========================================================
   // Clock, reset, pins and counters
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wp_b = 1'b1;
   logic cs_b, sck, mosi, miso, miso_oe, write_enable_latch, armed;
   logic [7:0] status;
   logic [63:0] rx;
   int fails = 0;
   int checks = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   fspid_top u_fspid_top (.CLK(clk), .RST_B(rst_b), .CS_B(cs_b),
      .SCK(sck), .MOSI(mosi), .WP_B(wp_b), .MISO(miso),
      .MISO_OE(miso_oe), .STATUS(status), .WRITE_ENABLE_LATCH(write_enable_latch),
      .ARMED(armed));
   // Undriven output line shows the inverse of the pin, never its last bit
   logic miso_line;
   assign miso_line = miso_oe ? miso : ~miso;
   fspid_host u_fspid_host (.clk(clk), .cs_b(cs_b), .sck(sck),
      .mosi(mosi), .miso(miso_line));
   // ==========================================================
   // Shared helpers
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic op8(input logic [7:0] op);
      u_fspid_host.frame(8, {56'h0, op}, rx);
   endtask : op8
   // Preceding one-byte frame, then a status write frame
   task automatic wr(input logic [7:0] pre, input logic [7:0] d);
      op8(pre);
      u_fspid_host.frame(16, {48'h0, fspid_pkg::OP_STATUS_WRITE, d}, rx);
   endtask : wr
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      check("status", status, fspid_pkg::ST_RESET);
      check("armed", armed, 1'b0);
      check("oe", miso_oe, 1'b0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_arm();
      op8(fspid_pkg::OP_STATUS_WRITE_ARM);
      check("armed", armed, 1'b1);
      u_fspid_host.frame(16, {48'h0, fspid_pkg::OP_STATUS_WRITE, 8'hFF}, rx);
      check("status", status, 8'hBC);
      check("armed", armed, 1'b0);
      wr(fspid_pkg::OP_STATUS_WRITE_ARM, 8'h00);
      check("status", status, 8'h00);
      $display("arm test done");
   endtask : t_arm
   task automatic t_refuse();
      // No arming at all, then a frame between arm and write
      wr(fspid_pkg::OP_WRITE_DISABLE, 8'h3C);
      check("status", status, 8'h00);
      op8(fspid_pkg::OP_STATUS_WRITE_ARM);
      wr(fspid_pkg::OP_WRITE_DISABLE, 8'h3C);
      check("status", status, 8'h00);
      check("armed", armed, 1'b0);
      $display("refuse test done");
   endtask : t_refuse
   task automatic t_write_enable_cmd();
      op8(fspid_pkg::OP_WRITE_ENABLE);
      check("wel", write_enable_latch, 1'b1);
      u_fspid_host.frame(16, {48'h0, fspid_pkg::OP_STATUS_WRITE, 8'h84}, rx);
      check("status", status, 8'h84);
      check("wel", write_enable_latch, 1'b0);
      $display("write enable test done");
   endtask : t_write_enable_cmd
   task automatic t_lock();
      wp_b = 1'b0;
      wr(fspid_pkg::OP_STATUS_WRITE_ARM, 8'h00);
      check("status", status, 8'h84);
      wp_b = 1'b1;
      wr(fspid_pkg::OP_STATUS_WRITE_ARM, 8'h00);
      check("status", status, 8'h00);
      wp_b = 1'b0;
      wr(fspid_pkg::OP_STATUS_WRITE_ARM, 8'hA0);
      check("status", status, 8'hA0);
      wr(fspid_pkg::OP_STATUS_WRITE_ARM, 8'h20);
      check("status", status, 8'hA0);
      wp_b = 1'b1;
      $display("lock test done");
   endtask : t_lock
   task automatic t_std();
      u_fspid_host.frame(40, {24'h0, fspid_pkg::OP_STANDARD_IDENT, 32'h0},
                         rx);
      check("ident", rx[31:0], {fspid_pkg::ID_MANUFACTURER,
         fspid_pkg::ID_MEMORY_TYPE, fspid_pkg::ID_CAPACITY,
         fspid_pkg::ID_MANUFACTURER});
      // Cut short in the middle of the second byte
      u_fspid_host.frame(20, {44'h0, fspid_pkg::OP_STANDARD_IDENT, 12'h0},
                         rx);
      check("short", rx[11:0], {fspid_pkg::ID_MANUFACTURER,
         fspid_pkg::ID_MEMORY_TYPE[7:4]});
      check("oe", miso_oe, 1'b0);
      $display("standard ident test done");
   endtask : t_std
   task automatic t_legacy();
      logic [7:0] op;
      logic [7:0] mf;
      logic [7:0] dv;
      mf = fspid_pkg::ID_MANUFACTURER;
      dv = fspid_pkg::ID_CAPACITY;
      // Both opcodes, both start addresses
      for (int k = 0; k < 4; k++) begin
         op = k[1] ? fspid_pkg::OP_LEGACY_IDENT_B :
                     fspid_pkg::OP_LEGACY_IDENT_A;
         u_fspid_host.frame(64, {op, 23'h0, k[0], 32'h0}, rx);
         check("legacy", rx[31:0],
            k[0] ? {dv, mf, dv, mf} : {mf, dv, mf, dv});
      end
      $display("legacy ident test done");
   endtask : t_legacy
   // ==========================================================
   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // Main sequence: reset two cycles, settle, then scenarios
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_reset();
      t_arm();
      t_refuse();
      t_write_enable_cmd();
      t_lock();
      t_std();
      t_legacy();
      close_out();
   end
   // Hang guard: a stuck run counts as a mismatch
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("[ERR] run limit expected done seen hang");
      close_out();
   end
endmodule : fspid_top_tb_top
